// ==== logic/lke_legacy_kbd.v ====
// Legacy keyboard/mouse emulation: port 60h/64h trap, buffers, status, A20 sequence
// Assumes single-cycle I/O strobes from the port decoder and a simple register port
`timescale 1ns/1ps
`include "lke_consts.vh"

module lke_legacy_kbd (
   input wire sys_clk_i, // 100 MHz system clock
   input wire rst_n_i, // Async reset, active low
   input wire reg_wr_i, // Register write strobe
   input wire reg_rd_i, // Register read strobe
   input wire [11:0] reg_addr_i, // Register byte address
   input wire [31:0] reg_wdata_i, // Register write data
   output reg [31:0] reg_rdata_o, // Register read data
   input wire io_wr_i, // Legacy I/O write strobe
   input wire io_rd_i, // Legacy I/O read strobe
   input wire io_port_i, // 0 = port 60h, 1 = port 64h
   input wire [7:0] io_wdata_i, // Legacy write byte
   output reg [7:0] io_rdata_o, // Legacy read byte
   output reg io_trap_o, // Access claimed by emulation
   input wire kbc_kbd_irq_i, // Keyboard controller keyboard line
   input wire kbc_mouse_irq_i, // Keyboard controller mouse line
   output reg keyboard_irq_line_o, // Emulated keyboard interrupt
   output reg mouse_irq_line_o, // Emulated mouse interrupt
   output reg emul_int_o // Emulation interrupt to software
);
   reg legacy_emul_en_r;
   reg char_pending_en_r;
   reg legacy_irq_en_r;
   reg external_irq_passthrough_en_r;
   reg a20_sequence_active_r;
   reg kbd_irq_edge_seen_r;
   reg mouse_irq_edge_seen_r;
   reg gate_a20_level_r;
   reg [7:0] in_buffer_byte_r;
   reg [7:0] out_buffer_byte_r;
   reg [7:0] status_r;
   reg [31:0] rdata_nxt;
   reg [7:0] io_rdata_nxt;
   reg emul_int_state;
   reg kbd_irq_nxt;
   reg mouse_irq_nxt;
   wire kbd_level;
   wire kbd_rise;
   wire mouse_level;
   wire mouse_rise;
   wire io_wr_hit;
   wire io_rd_hit;
   wire data_wr;
   wire cmd_wr;
   wire a20_data_wr;
   wire ctrl_wr;
   wire stat_wr;
   wire [8:0] ctrl_view;
   wire in_wr;
   wire out_wr;
   wire data_rd;
   reg legacy_emul_en_nxt;
   reg char_pending_en_nxt;
   reg legacy_irq_en_nxt;
   reg external_irq_passthrough_en_nxt;
   reg a20_sequence_active_nxt;
   reg kbd_irq_edge_seen_nxt;
   reg mouse_irq_edge_seen_nxt;
   reg gate_a20_level_nxt;
   reg [7:0] in_buffer_byte_nxt;
   reg [7:0] out_buffer_byte_nxt;
   reg [7:0] status_nxt;

   // Register address compare
   function hit;
      input [11:0] addr;
      input [11:0] off;
      begin
         hit = (addr[11:2] == off[11:2]);
      end
   endfunction

   // Legacy line request for the buffer owner chosen by want_aux
   function line_req;
      input en;
      input irq_en;
      input full;
      input aux;
      input want_aux;
      begin
         line_req = en & irq_en & full & (aux == want_aux);
      end
   endfunction

   // Keyboard controller line synchronisers
   lke_edge_sync u_kbd_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(kbc_kbd_irq_i),
      .level_o(kbd_level),
      .rise_o(kbd_rise)
   );

   lke_edge_sync u_mouse_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(kbc_mouse_irq_i),
      .level_o(mouse_level),
      .rise_o(mouse_rise)
   );

   // Legacy accesses claimed only while emulation is on
   // decode gated by enable
   assign io_wr_hit = io_wr_i & legacy_emul_en_r;
   assign io_rd_hit = io_rd_i & legacy_emul_en_r;
   assign data_wr = io_wr_hit & (io_port_i == `LKE_PORT_DATA);
   assign cmd_wr = io_wr_hit & (io_port_i == `LKE_PORT_CMD);
   // Data write during an A20 sequence, which it leaves active
   assign a20_data_wr = data_wr & a20_sequence_active_r;
   assign ctrl_wr = reg_wr_i & hit(reg_addr_i, `LKE_OFF_CTRL);
   assign stat_wr = reg_wr_i & hit(reg_addr_i, `LKE_OFF_STAT);
   // Buffer register writes and data port read
   assign in_wr = reg_wr_i & hit(reg_addr_i, `LKE_OFF_IN);
   assign out_wr = reg_wr_i & hit(reg_addr_i, `LKE_OFF_OUT);
   assign data_rd = io_rd_hit & (io_port_i == `LKE_PORT_DATA);

   // Control register as software reads it
   assign ctrl_view = {gate_a20_level_r, mouse_irq_edge_seen_r, kbd_irq_edge_seen_r,
                       a20_sequence_active_r, external_irq_passthrough_en_r, legacy_irq_en_r,
                       char_pending_en_r, emul_int_state, legacy_emul_en_r};

   // Emulation interrupt condition and legacy IRQ decode
   always @* begin
      emul_int_state = 1'b0;
      if (legacy_emul_en_r && status_r[`LKE_S_IN_FULL]) begin
         emul_int_state = 1'b1;
      end
      if (legacy_emul_en_r && char_pending_en_r && !status_r[`LKE_S_OUT_FULL]) begin
         emul_int_state = 1'b1;
      end
      if (external_irq_passthrough_en_r && (kbd_level || mouse_level)) begin
         emul_int_state = 1'b1;
      end
   end

   // steer by aux bit
   // Both lines need emulation and legacy IRQ enable
   always @* begin
      kbd_irq_nxt = line_req(legacy_emul_en_r, legacy_irq_en_r, status_r[`LKE_S_OUT_FULL],
                             status_r[`LKE_S_AUX], 1'b0);
      mouse_irq_nxt = line_req(legacy_emul_en_r, legacy_irq_en_r, status_r[`LKE_S_OUT_FULL],
                               status_r[`LKE_S_AUX], 1'b1);
   end

   // Control fields: software write, then port command tracking
   always @* begin
      legacy_emul_en_nxt = legacy_emul_en_r;
      char_pending_en_nxt = char_pending_en_r;
      legacy_irq_en_nxt = legacy_irq_en_r;
      external_irq_passthrough_en_nxt = external_irq_passthrough_en_r;
      a20_sequence_active_nxt = a20_sequence_active_r;
      gate_a20_level_nxt = gate_a20_level_r;
      if (ctrl_wr) begin
         legacy_emul_en_nxt = reg_wdata_i[`LKE_C_EMUL_EN];
         char_pending_en_nxt = reg_wdata_i[`LKE_C_CHAR_PEND];
         legacy_irq_en_nxt = reg_wdata_i[`LKE_C_IRQ_EN];
         external_irq_passthrough_en_nxt = reg_wdata_i[`LKE_C_EXT_IRQ];
         a20_sequence_active_nxt = reg_wdata_i[`LKE_C_A20_SEQ];
         gate_a20_level_nxt = reg_wdata_i[`LKE_C_A20_LVL];
      end
      if (cmd_wr) begin
         a20_sequence_active_nxt = (io_wdata_i == `LKE_CMD_A20);
      end
   end

   // Edge flags: write one clears, a same-cycle pin rise wins
   always @* begin
      kbd_irq_edge_seen_nxt = kbd_irq_edge_seen_r;
      mouse_irq_edge_seen_nxt = mouse_irq_edge_seen_r;
      if (kbd_rise) begin
         kbd_irq_edge_seen_nxt = 1'b1;
      end else if (ctrl_wr && reg_wdata_i[`LKE_C_KBD_EDGE]) begin
         kbd_irq_edge_seen_nxt = 1'b0;
      end
      if (mouse_rise) begin
         mouse_irq_edge_seen_nxt = 1'b1;
      end else if (ctrl_wr && reg_wdata_i[`LKE_C_MOUSE_EDGE]) begin
         mouse_irq_edge_seen_nxt = 1'b0;
      end
   end

   // Control register and sticky flags
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         legacy_emul_en_r <= 1'b0;
         char_pending_en_r <= 1'b0;
         legacy_irq_en_r <= 1'b0;
         external_irq_passthrough_en_r <= 1'b0;
         a20_sequence_active_r <= 1'b0;
         kbd_irq_edge_seen_r <= 1'b0;
         mouse_irq_edge_seen_r <= 1'b0;
         gate_a20_level_r <= 1'b0;
      end else begin
         legacy_emul_en_r <= legacy_emul_en_nxt;
         char_pending_en_r <= char_pending_en_nxt;
         legacy_irq_en_r <= legacy_irq_en_nxt;
         external_irq_passthrough_en_r <= external_irq_passthrough_en_nxt;
         a20_sequence_active_r <= a20_sequence_active_nxt;
         kbd_irq_edge_seen_r <= kbd_irq_edge_seen_nxt;
         mouse_irq_edge_seen_r <= mouse_irq_edge_seen_nxt;
         gate_a20_level_r <= gate_a20_level_nxt;
      end
   end

   // Buffer bytes: port write overrides a same-cycle input buffer register write
   always @* begin
      in_buffer_byte_nxt = in_buffer_byte_r;
      out_buffer_byte_nxt = out_buffer_byte_r;
      if (in_wr) begin
         in_buffer_byte_nxt = reg_wdata_i[7:0];
      end
      if (out_wr) begin
         out_buffer_byte_nxt = reg_wdata_i[7:0];
      end
      if (io_wr_hit) begin
         in_buffer_byte_nxt = io_wdata_i;
      end
   end

   // Status byte: hardware events override a software write
   always @* begin
      status_nxt = status_r;
      if (stat_wr) begin
         status_nxt = reg_wdata_i[7:0];
      end
      if (io_wr_hit) begin
         status_nxt[`LKE_S_CMD] = (io_port_i == `LKE_PORT_CMD);
      end
      if (io_wr_hit && !a20_data_wr) begin
         status_nxt[`LKE_S_IN_FULL] = 1'b1;
      end
      if (data_rd) begin
         status_nxt[`LKE_S_OUT_FULL] = 1'b0;
      end
   end

   // Buffers and status byte
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_buffer_byte_r <= `LKE_RST_BYTE;
         out_buffer_byte_r <= `LKE_RST_BYTE;
         status_r <= `LKE_RST_STAT;
      end else begin
         in_buffer_byte_r <= in_buffer_byte_nxt;
         out_buffer_byte_r <= out_buffer_byte_nxt;
         status_r <= status_nxt;
      end
   end

   // Register read data by offset
   always @* begin
      rdata_nxt = 32'h0000_0000;
      if (hit(reg_addr_i, `LKE_OFF_CTRL)) begin
         rdata_nxt = {23'h000000, ctrl_view};
      end else if (hit(reg_addr_i, `LKE_OFF_IN)) begin
         rdata_nxt = {24'h000000, in_buffer_byte_r};
      end else if (hit(reg_addr_i, `LKE_OFF_OUT)) begin
         rdata_nxt = {24'h000000, out_buffer_byte_r};
      end else if (hit(reg_addr_i, `LKE_OFF_STAT)) begin
         rdata_nxt = {24'h000000, status_r};
      end
   end

   // Legacy read data by port
   always @* begin
      io_rdata_nxt = 8'h00;
      if (io_port_i == `LKE_PORT_DATA) begin
         io_rdata_nxt = out_buffer_byte_r;
      end else begin
         io_rdata_nxt = status_r;
      end
   end

   // Registered read data, zero outside a read
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 32'h0000_0000;
         io_rdata_o <= 8'h00;
      end else begin
         reg_rdata_o <= reg_rd_i ? rdata_nxt : 32'h0000_0000;
         io_rdata_o <= io_rd_hit ? io_rdata_nxt : 8'h00;
      end
   end

   // Trap pulse for a claimed port access
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         io_trap_o <= 1'b0;
      end else begin
         io_trap_o <= io_wr_hit | io_rd_hit;
      end
   end

   // Registered interrupt outputs
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         keyboard_irq_line_o <= 1'b0;
         mouse_irq_line_o <= 1'b0;
         emul_int_o <= 1'b0;
      end else begin
         keyboard_irq_line_o <= kbd_irq_nxt;
         mouse_irq_line_o <= mouse_irq_nxt;
         emul_int_o <= emul_int_state;
      end
   end
endmodule

// ==== logic/lke_consts.vh ====
// Legacy keyboard emulation: offsets, bit positions, reset values, port codes
// Assumes byte addresses on the emulation register port, 32-bit data
`ifndef LKE_CONSTS_VH
`define LKE_CONSTS_VH
// Register byte offsets
`define LKE_OFF_CTRL 12'h100
`define LKE_OFF_IN 12'h104
`define LKE_OFF_OUT 12'h108
`define LKE_OFF_STAT 12'h10c
// Control bit positions
`define LKE_C_EMUL_EN 0
`define LKE_C_EMUL_INT 1
`define LKE_C_CHAR_PEND 2
`define LKE_C_IRQ_EN 3
`define LKE_C_EXT_IRQ 4
`define LKE_C_A20_SEQ 5
`define LKE_C_KBD_EDGE 6
`define LKE_C_MOUSE_EDGE 7
`define LKE_C_A20_LVL 8
// Status bit positions
`define LKE_S_OUT_FULL 0
`define LKE_S_IN_FULL 1
`define LKE_S_FLAG 2
`define LKE_S_CMD 3
`define LKE_S_INHIBIT 4
`define LKE_S_AUX 5
`define LKE_S_TIMEOUT 6
`define LKE_S_PARITY 7
// Legacy ports and commands
`define LKE_PORT_DATA 1'b0
`define LKE_PORT_CMD 1'b1
`define LKE_CMD_A20 8'hd1
// Reset values
`define LKE_RST_CTRL 9'h000
`define LKE_RST_STAT 8'h00
`define LKE_RST_BYTE 8'h00
`endif

// ==== logic/lke_edge_sync.v ====
// Two-flop synchroniser with rising edge detect for one pin
// Assumes pin is asynchronous to sys_clk_i
`timescale 1ns/1ps
module lke_edge_sync (
   input wire sys_clk_i, // System clock
   input wire rst_n_i, // Async reset, active low
   input wire pin_i, // Asynchronous pin
   output wire level_o, // Synchronised level
   output wire rise_o // One-cycle rising pulse
);
   reg meta_r;
   reg sync_r;
   reg prev_r;

   // Sync chain and previous level
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level_o = sync_r;
   assign rise_o = sync_r & ~prev_r;
endmodule

// ==== testbench/lke_legacy_kbd_props.sv ====
// Port checker for the legacy keyboard emulation block
// Assumes binding onto lke_legacy_kbd, single clock domain
`timescale 1ns/1ps
`include "lke_consts.vh"
module lke_legacy_kbd_props (
   input wire sys_clk_i, // Clock
   input wire rst_n_i, // Reset
   input wire reg_wr_i, // Reg write
   input wire reg_rd_i, // Reg read
   input wire [11:0] reg_addr_i, // Reg address
   input wire [31:0] reg_wdata_i, // Reg data
   input wire [31:0] reg_rdata_o, // Reg read data
   input wire io_wr_i, // Port write
   input wire io_rd_i, // Port read
   input wire io_port_i, // Port select
   input wire [7:0] io_wdata_i, // Port data
   input wire [7:0] io_rdata_o, // Port read data
   input wire io_trap_o, // Trap pulse
   input wire kbc_kbd_irq_i, // Keyboard pin
   input wire kbc_mouse_irq_i, // Mouse pin
   input wire keyboard_irq_line_o, // Keyboard line
   input wire mouse_irq_line_o, // Mouse line
   input wire emul_int_o // Emulation int
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Output relations
   trap_cause_a: assert property (io_trap_o |-> $past(io_wr_i || io_rd_i))
      else $error("trap without access");
   irq_excl_a: assert property (!(keyboard_irq_line_o && mouse_irq_line_o))
      else $error("both legacy lines high");
   rdata_idle_a: assert property (reg_rdata_o != 32'h0 |-> $past(reg_rd_i) && reg_rdata_o[31:9] == 23'h0)
      else $error("register data out of turn");
   upper_zero_a: assert property (reg_rd_i && reg_addr_i != `LKE_OFF_CTRL |=> reg_rdata_o[31:8] == 24'h0)
      else $error("upper bits not zero");
   io_rdata_a: assert property (io_rdata_o != 8'h0 |-> $past(io_rd_i) && io_trap_o)
      else $error("port data out of turn");
   cmd_int_a: assert property (io_trap_o && $past(io_wr_i && io_port_i) |=> emul_int_o)
      else $error("no interrupt after command write");
   rd_clear_a: assert property (io_trap_o && $past(io_rd_i && !io_port_i) |=> !keyboard_irq_line_o && !mouse_irq_line_o)
      else $error("line held after data read");
   cmd_bit_a: assert property (io_trap_o && $past(io_wr_i) && io_rd_i && io_port_i |=> io_rdata_o[3] == $past(io_port_i, 2))
      else $error("command flag wrong");
   int_bit_a: assert property (reg_rd_i && reg_addr_i == `LKE_OFF_CTRL |=> reg_rdata_o[1] == emul_int_o)
      else $error("interrupt bit differs from output");
endmodule
bind lke_legacy_kbd lke_legacy_kbd_props u_props (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_port_i(io_port_i),
   .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_trap_o(io_trap_o), .kbc_kbd_irq_i(kbc_kbd_irq_i),
   .kbc_mouse_irq_i(kbc_mouse_irq_i), .keyboard_irq_line_o(keyboard_irq_line_o),
   .mouse_irq_line_o(mouse_irq_line_o), .emul_int_o(emul_int_o));

// ==== testbench/lke_app_sw.sv ====
// Legacy software model driving port 60h/64h accesses
// Assumes the caller issues one operation per clock
`timescale 1ns/1ps
module lke_app_sw (
   input wire sys_clk_i, // Clock
   output logic io_wr_o = 1'b0, // Write strobe
   output logic io_rd_o = 1'b0, // Read strobe
   output logic io_port_o = 1'b0, // Port select
   output logic [7:0] io_wdata_o = 8'h00 // Data byte
);
   // One access per edge, held one cycle
   task io_op(input logic wr, input logic port, input logic [7:0] d);
      @(posedge sys_clk_i);
      io_wr_o <= wr;
      io_rd_o <= !wr;
      io_port_o <= port;
      io_wdata_o <= d;
   endtask
   // Released lines carry scrambled values
   task io_idle;
      @(posedge sys_clk_i);
      io_wr_o <= 1'b0;
      io_rd_o <= 1'b0;
      io_port_o <= ~io_port_o;
      io_wdata_o <= ~io_wdata_o;
   endtask
endmodule

// ==== testbench/lke_legacy_kbd_tb_top.sv ====
// Self-checking bench for the legacy keyboard emulation block
// Assumes the checker is bound to the design by its own file
`timescale 1ns/1ps
`include "lke_consts.vh"
module lke_legacy_kbd_tb_top;
   logic sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i, kbd_pin, mouse_pin, kbd_irq, mouse_irq, emul_int_o;
   logic io_wr_i, io_rd_i, io_port_i, io_trap_o, reg_d = 1'b0, io_d = 1'b0;
   logic [11:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, seed, r;
   logic [7:0] io_wdata_i, io_rdata_o;
   logic [31:0] exp_q[$];
   int n_fail = 0, cmp_count = 0;
   lke_legacy_kbd dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .io_wr_i(io_wr_i),
      .io_rd_i(io_rd_i), .io_port_i(io_port_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
      .io_trap_o(io_trap_o), .kbc_kbd_irq_i(kbd_pin), .kbc_mouse_irq_i(mouse_pin),
      .keyboard_irq_line_o(kbd_irq), .mouse_irq_line_o(mouse_irq), .emul_int_o(emul_int_o));
   lke_app_sw sw (.sys_clk_i(sys_clk_i), .io_wr_o(io_wr_i), .io_rd_o(io_rd_i), .io_port_o(io_port_i),
      .io_wdata_o(io_wdata_i));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask
   // Register access; a read notes its expected word
   task reg_op(input logic wr, input logic [11:0] a, input logic [31:0] d);
      sw.io_idle;
      reg_wr_i <= wr;
      reg_rd_i <= !wr;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      if (!wr) exp_q.push_back(d);
   endtask
   task io(input logic wr, input logic port, input logic [7:0] d, input logic [7:0] e);
      sw.io_op(wr, port, d);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      if (!wr) exp_q.push_back({24'h0, e});
   endtask
   task idle(input int n);
      repeat (n) begin
         sw.io_idle;
         reg_wr_i <= 1'b0;
         reg_rd_i <= 1'b0;
      end
      #1;
   endtask
   task close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Read data checked one cycle after each read
   always @(posedge sys_clk_i) begin
      if (reg_d || io_d) chk(reg_d ? reg_rdata_o : {24'h0, io_rdata_o}, exp_q.pop_front());
      reg_d = reg_rd_i;
      io_d = io_rd_i;
   end
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      #200000;
      n_fail++;
      close_out;
   end
   initial begin
      {rst_n_i, reg_wr_i, reg_rd_i, kbd_pin, mouse_pin} = 5'h0;
      reg_addr_i = 12'h000;
      reg_wdata_i = 32'h0;
      seed = 32'h52fcf875;
      repeat (20) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      // Reset state, unmapped place, disabled port
      reg_op(1, 12'h110, seed);
      for (int i = 0; i < 5; i++) reg_op(0, 12'h100 + 12'(4 * i), 32'h0);
      io(1, 0, 8'h5a, 0);
      idle(1);
      chk(io_trap_o, 0);
      reg_op(0, `LKE_OFF_IN, 32'h0);
      seed = xs(seed);
      r = xs(seed);
      reg_op(1, `LKE_OFF_CTRL, 32'h1);
      reg_op(1, `LKE_OFF_STAT, seed & 32'hffff_fffc);
      reg_op(0, `LKE_OFF_STAT, {24'h0, seed[7:2], 2'b00});
      reg_op(1, `LKE_OFF_OUT, r);
      reg_op(0, `LKE_OFF_OUT, {24'h0, r[7:0]});
      $display("test registers done");
      // Output full drives one of two lines
      for (int a = 0; a < 2; a++) begin
         reg_op(1, `LKE_OFF_STAT, 32'h1 | (a << 5));
         reg_op(1, `LKE_OFF_CTRL, 32'h9);
         idle(3);
         chk({30'h0, mouse_irq, kbd_irq}, a ? 32'h2 : 32'h1);
      end
      io(0, 0, 8'h00, r[7:0]);
      idle(3);
      chk({30'h0, mouse_irq, kbd_irq}, 32'h0);
      reg_op(0, `LKE_OFF_STAT, 32'h20);
      $display("test output buffer done");
      // Port writes, gate sequence
      r = xs(r);
      io(1, 0, r[7:0], 0);
      io(0, 1, 8'h00, 8'h22);
      idle(2);
      chk(emul_int_o, 1);
      reg_op(0, `LKE_OFF_IN, {24'h0, r[7:0]});
      reg_op(0, `LKE_OFF_CTRL, 32'hb);
      io(1, 1, `LKE_CMD_A20, 0);
      reg_op(0, `LKE_OFF_CTRL, 32'h2b);
      reg_op(1, `LKE_OFF_STAT, 32'h0);
      io(1, 0, r[15:8], 0);
      reg_op(0, `LKE_OFF_STAT, 32'h0);
      reg_op(0, `LKE_OFF_IN, {24'h0, r[15:8]});
      reg_op(0, `LKE_OFF_CTRL, 32'h29);
      io(1, 1, r[23:16] & 8'hfe, 0);
      idle(1);
      chk(io_trap_o, 1);
      reg_op(0, `LKE_OFF_CTRL, 32'hb);
      reg_op(0, `LKE_OFF_STAT, 32'ha);
      $display("test port writes done");
      // Pending character, gate level
      reg_op(1, `LKE_OFF_STAT, 32'h0);
      reg_op(1, `LKE_OFF_CTRL, 32'h5);
      reg_op(0, `LKE_OFF_CTRL, 32'h7);
      idle(2);
      chk(emul_int_o, 1);
      reg_op(1, `LKE_OFF_STAT, 32'h1);
      reg_op(0, `LKE_OFF_CTRL, 32'h5);
      idle(2);
      chk(emul_int_o, 0);
      reg_op(1, `LKE_OFF_CTRL, 32'hffff_ff00);
      reg_op(0, `LKE_OFF_CTRL, 32'h100);
      $display("test pending done");
      // Pin edges and pass-through
      for (int p = 0; p < 2; p++) begin
         reg_op(1, `LKE_OFF_CTRL, 32'h10);
         if (p) mouse_pin <= 1'b1;
         else kbd_pin <= 1'b1;
         idle(6);
         chk(emul_int_o, 1);
         reg_op(1, `LKE_OFF_CTRL, 32'h10);
         reg_op(0, `LKE_OFF_CTRL, 32'h12 | (32'h40 << p));
         reg_op(1, `LKE_OFF_CTRL, 32'h10 | (32'h40 << p));
         reg_op(0, `LKE_OFF_CTRL, 32'h12);
         kbd_pin <= 1'b0;
         mouse_pin <= 1'b0;
         idle(6);
         reg_op(0, `LKE_OFF_CTRL, 32'h10);
      end
      idle(3);
      $display("test edges done");
      close_out;
   end
endmodule
